// >>> logic/fdk_defs.vh
// Register map, field positions, reset values and codes of the flash download block
`ifndef FDK_DEFS_VH
`define FDK_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address on the plain port)
// ----------------------------------------------------------------------
`define FDK_ADDR_W          3
`define FDK_OFS_DL_CTRL     3'h0
`define FDK_OFS_PROG_SEL    3'h1
`define FDK_OFS_ERASE_SEL   3'h2
`define FDK_OFS_KEY         3'h3
`define FDK_OFS_ARRAY_SEL   3'h4
`define FDK_OFS_STATUS      3'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FDK_BIT_COPY_REQ    0
`define FDK_BIT_CHOOSE      0
`define FDK_BIT_ST_BUSY     0
`define FDK_BIT_ST_BOOT     1
`define FDK_BIT_ST_PE_EN    2
`define FDK_BIT_ST_REFUSED  3

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define FDK_KEY_COPY        8'ha5
`define FDK_KEY_PROG_ERASE  8'h5a
`define FDK_ARRAY_BOOT      8'haa
`define FDK_ARRAY_USER_RST  8'h00
`define FDK_KEY_RST         8'h00
`define FDK_SEL_RST         8'h00

// ----------------------------------------------------------------------
// Download timing
// ----------------------------------------------------------------------
`define FDK_RAM_ADDR_W      8
`define FDK_DL_WORDS        8'h40

`endif

// >>> logic/fdk_top.v
// Flash download key, routine select and array select registers with download engine
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fdk_defs.vh"


module fdk_top (
  input  wire                        clk,
  input  wire                        rst,
  input  wire [`FDK_ADDR_W-1:0]      addr,
  input  wire [7:0]                  wdata,
  input  wire                        wr,
  input  wire                        rd,
  output reg  [7:0]                  rdata,
  input  wire                        mode_user_boot,
  input  wire                        mode_user_prog,
  input  wire                        ram_emulation,
  input  wire                        exec_from_ram,
  output reg                         boot_array_sel,
  output reg                         prog_erase_enable,
  output reg                         software_protect,
  output reg                         dl_busy,
  output reg                         dl_erase,
  output reg                         dl_done,
  output reg                         ram_we,
  output reg  [`FDK_RAM_ADDR_W-1:0]  ram_addr
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Left unreset so the boot strap is already valid while reset is held
  reg [1:0] boot_sync;
  reg [1:0] prog_sync;
  reg [1:0] emu_sync;

  always @(posedge clk) begin
    boot_sync <= {boot_sync[0], mode_user_boot};
    prog_sync <= {prog_sync[0], mode_user_prog};
    emu_sync  <= {emu_sync[0], ram_emulation};
  end

  wire user_boot = boot_sync[1];
  wire user_prog = prog_sync[1];
  wire emu_on    = emu_sync[1];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function is_wr;
    input [`FDK_ADDR_W-1:0] a;
    input [`FDK_ADDR_W-1:0] ofs;
    begin
      is_wr = wr && (a == ofs);
    end
  endfunction

  function boot_mapped;
    input [7:0] sel;
    input       prog_mode;
    begin
      boot_mapped = (sel == `FDK_ARRAY_BOOT) && !prog_mode;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg                        program_routine_choose;
  reg                        erase_routine_choose;
  reg [7:0]                  key_reg;
  reg [7:0]                  array_select_reg;
  reg                        copy_request;
  reg                        copy_refused;
  reg [`FDK_RAM_ADDR_W-1:0]  dl_count;

  wire wr_ctrl  = is_wr(addr, `FDK_OFS_DL_CTRL);
  wire wr_psel  = is_wr(addr, `FDK_OFS_PROG_SEL);
  wire wr_esel  = is_wr(addr, `FDK_OFS_ERASE_SEL);
  wire wr_key   = is_wr(addr, `FDK_OFS_KEY);
  wire wr_array = is_wr(addr, `FDK_OFS_ARRAY_SEL);
  wire wr_stat  = is_wr(addr, `FDK_OFS_STATUS);

  wire set_try  = wr_ctrl && wdata[`FDK_BIT_COPY_REQ] && !copy_request;
  // All three conditions must hold at the setting write
  wire set_ok   = set_try && !emu_on && (key_reg == `FDK_KEY_COPY) && exec_from_ram;
  wire last_wd  = copy_request && (dl_count == `FDK_DL_WORDS - 8'h01);

  always @(posedge clk) begin
    if (rst) begin
      program_routine_choose <= 1'b0;
      erase_routine_choose   <= 1'b0;
      key_reg                <= `FDK_KEY_RST;
      array_select_reg       <= user_boot ? `FDK_ARRAY_BOOT : `FDK_ARRAY_USER_RST;
      copy_request           <= 1'b0;
      copy_refused           <= 1'b0;
      dl_count               <= {`FDK_RAM_ADDR_W{1'b0}};
    end else begin
      // Routine choice frozen while a copy runs so the source cannot change mid-way
      if (last_wd) begin
        program_routine_choose <= 1'b0;
        erase_routine_choose   <= 1'b0;
      end else if (!copy_request) begin
        if (wr_psel)
          program_routine_choose <= wdata[`FDK_BIT_CHOOSE];
        if (wr_esel)
          erase_routine_choose <= wdata[`FDK_BIT_CHOOSE];
      end
      if (wr_key)
        key_reg <= wdata;
      // Placement in RAM is the caller's duty; hardware accepts any write
      if (wr_array)
        array_select_reg <= wdata;
      if (set_ok) begin
        copy_request <= 1'b1;
        dl_count     <= {`FDK_RAM_ADDR_W{1'b0}};
      end else if (last_wd) begin
        copy_request <= 1'b0;
      end else if (copy_request) begin
        dl_count <= dl_count + 8'h01;
      end
      // Refused attempt is sticky; a new refusal wins over a clear
      if (set_try && !set_ok)
        copy_refused <= 1'b1;
      else if (wr_stat && wdata[`FDK_BIT_ST_REFUSED])
        copy_refused <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      boot_array_sel    <= 1'b0;
      prog_erase_enable <= 1'b0;
      software_protect  <= 1'b1;
      dl_busy           <= 1'b0;
      dl_erase          <= 1'b0;
      dl_done           <= 1'b0;
      ram_we            <= 1'b0;
      ram_addr          <= {`FDK_RAM_ADDR_W{1'b0}};
    end else begin
      boot_array_sel    <= boot_mapped(array_select_reg, user_prog);
      prog_erase_enable <= (key_reg == `FDK_KEY_PROG_ERASE);
      software_protect  <= (key_reg != `FDK_KEY_PROG_ERASE);
      dl_busy           <= copy_request;
      dl_erase          <= erase_routine_choose && !program_routine_choose;
      dl_done           <= last_wd;
      // Nothing chosen means the copy runs but writes no RAM
      ram_we            <= copy_request && (program_routine_choose || erase_routine_choose);
      ram_addr          <= dl_count;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr == `FDK_OFS_DL_CTRL)
        rdata <= 8'h00;
      else if (addr == `FDK_OFS_PROG_SEL)
        rdata <= {7'h00, program_routine_choose};
      else if (addr == `FDK_OFS_ERASE_SEL)
        rdata <= {7'h00, erase_routine_choose};
      else if (addr == `FDK_OFS_KEY)
        rdata <= key_reg;
      else if (addr == `FDK_OFS_ARRAY_SEL)
        rdata <= array_select_reg;
      else if (addr == `FDK_OFS_STATUS)
        rdata <= {4'h0, copy_refused, (key_reg == `FDK_KEY_PROG_ERASE),
                  boot_mapped(array_select_reg, user_prog), copy_request};
      else
        rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// >>> verif/fdk_asserts.sv
// Port-level assertions for the flash download key and array select block
`timescale 1ns/1ps
`include "fdk_defs.vh"
module fdk_asserts (
  input wire       clk,
  input wire       rst,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       mode_user_prog,
  input wire       exec_from_ram,
  input wire       boot_array_sel,
  input wire       prog_erase_enable,
  input wire       software_protect,
  input wire       dl_busy,
  input wire       dl_done,
  input wire       ram_we,
  input wire [7:0] ram_addr
);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside reply cycle");
  a_key_protect: assert property (software_protect == !prog_erase_enable)
    else $error("protect and enable disagree");
  a_key_enable: assert property (wr && addr == `FDK_OFS_KEY && wdata == 8'h5a |-> ##[1:2] prog_erase_enable)
    else $error("key 5a did not enable program or erase");
  a_copy_refused: assert property (wr && addr == `FDK_OFS_DL_CTRL && wdata[0] && !exec_from_ram && !dl_busy
    |=> !dl_busy [*4]) else $error("copy started outside ram");
  a_done_pulse: assert property (dl_done |=> !dl_done ##0 !dl_busy)
    else $error("done not a single pulse ending the copy");
  a_we_busy: assert property (ram_we |-> dl_busy)
    else $error("ram write outside copy");
  a_copy_start: assert property ($rose(dl_busy) |-> ram_addr == 8'h00)
    else $error("copy not starting at word zero");
  a_prog_block: assert property (mode_user_prog [*5] |-> !boot_array_sel)
    else $error("boot array mapped in user programming mode");
  a_boot_map: assert property (!mode_user_prog [*4] ##0 (wr && addr == `FDK_OFS_ARRAY_SEL && wdata == 8'haa)
    |-> ##[1:2] boot_array_sel) else $error("array code aa did not map boot array");
  a_user_map: assert property (wr && addr == `FDK_OFS_ARRAY_SEL && wdata != 8'haa |-> ##[1:2] !boot_array_sel)
    else $error("other array code kept boot array");
  c_done: cover property (dl_done);
  c_boot: cover property ($rose(boot_array_sel));
  c_enable: cover property ($rose(prog_erase_enable));
endmodule

// >>> verif/tb.sv
// Register-level testbench of the flash download block
`timescale 1ns/1ps
`include "fdk_defs.vh"
module tb;
  reg        clk, rst, wr, rd, mode_user_boot, mode_user_prog, ram_emulation, exec_from_ram;
  reg  [2:0] addr;
  reg  [7:0] wdata;
  wire [7:0] rdata, ram_addr;
  wire       boot_array_sel, prog_erase_enable, software_protect, dl_busy, dl_erase, dl_done, ram_we;
  integer    err_total, checks, cyc;
  reg        saw, saw_er;
  fdk_top uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mode_user_boot(mode_user_boot), .mode_user_prog(mode_user_prog), .ram_emulation(ram_emulation),
    .exec_from_ram(exec_from_ram), .boot_array_sel(boot_array_sel), .prog_erase_enable(prog_erase_enable),
    .software_protect(software_protect), .dl_busy(dl_busy), .dl_erase(dl_erase), .dl_done(dl_done),
    .ram_we(ram_we), .ram_addr(ram_addr));
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task chk(input string n, input [7:0] e, input [7:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task wrt(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rdc(input [2:0] a, input [7:0] e, input string n);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
    end
  endtask
  // Synchronised pins need two edges; the task waits four before the request
  task go(input [7:0] k, input e, input r, input x);
    integer i;
    begin
      wrt(`FDK_OFS_KEY, k);
      ram_emulation <= e;
      exec_from_ram <= r;
      repeat (4) @(posedge clk);
      wrt(`FDK_OFS_DL_CTRL, 8'h01);
      exec_from_ram <= 1'b0;
      saw = 1'b0;
      saw_er = 1'b0;
      for (i = 0; i < 100; i = i + 1) begin
        @(posedge clk);
        #1 if (dl_done === 1'b1) saw = 1'b1;
        if (dl_erase === 1'b1 && dl_busy === 1'b1) saw_er = 1'b1;
      end
      ram_emulation <= 1'b0;
      chk("copy done", {7'h0, x}, {7'h0, saw});
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  initial begin
    {rst, wr, rd, mode_user_boot, mode_user_prog, ram_emulation, exec_from_ram} = 7'h40;
    addr = 3'h0;
    wdata = 8'h00;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`FDK_OFS_KEY, 8'h00, "key reset");
    rdc(`FDK_OFS_ARRAY_SEL, 8'h00, "array reset");
    chk("protect", 8'h01, {7'h0, software_protect});
    wrt(`FDK_OFS_PROG_SEL, 8'hff);
    rdc(`FDK_OFS_PROG_SEL, 8'h01, "prog sel");
    wrt(`FDK_OFS_ERASE_SEL, 8'hff);
    rdc(`FDK_OFS_ERASE_SEL, 8'h01, "erase sel");
    wrt(`FDK_OFS_ERASE_SEL, 8'h00);
    rdc(3'h7, 8'h00, "unmapped");
    wrt(`FDK_OFS_KEY, 8'h5a);
    repeat (2) @(posedge clk);
    #1 chk("enable", 8'h01, {7'h0, prog_erase_enable});
    $display("test select and key done");
    // Array select is only written while running from RAM
    exec_from_ram <= 1'b1;
    wrt(`FDK_OFS_ARRAY_SEL, 8'haa);
    rdc(`FDK_OFS_ARRAY_SEL, 8'haa, "array sel");
    chk("boot map", 8'h01, {7'h0, boot_array_sel});
    wrt(`FDK_OFS_ARRAY_SEL, 8'h55);
    repeat (2) @(posedge clk);
    #1 chk("user map", 8'h00, {7'h0, boot_array_sel});
    mode_user_prog <= 1'b1;
    repeat (4) @(posedge clk);
    wrt(`FDK_OFS_ARRAY_SEL, 8'haa);
    repeat (3) @(posedge clk);
    #1 chk("prog mode map", 8'h00, {7'h0, boot_array_sel});
    mode_user_prog <= 1'b0;
    wrt(`FDK_OFS_ARRAY_SEL, 8'h00);
    exec_from_ram <= 1'b0;
    $display("test array select done");
    go(8'h00, 1'b0, 1'b1, 1'b0);
    rdc(`FDK_OFS_STATUS, 8'h08, "refused flag");
    wrt(`FDK_OFS_STATUS, 8'h08);
    rdc(`FDK_OFS_STATUS, 8'h00, "refused clear");
    go(8'ha5, 1'b1, 1'b1, 1'b0);
    go(8'ha5, 1'b0, 1'b0, 1'b0);
    rdc(`FDK_OFS_PROG_SEL, 8'h01, "prog kept");
    go(8'ha5, 1'b0, 1'b1, 1'b1);
    rdc(`FDK_OFS_PROG_SEL, 8'h00, "prog cleared");
    wrt(`FDK_OFS_ERASE_SEL, 8'h01);
    go(8'ha5, 1'b0, 1'b1, 1'b1);
    chk("erase copy", 8'h01, {7'h0, saw_er});
    rdc(`FDK_OFS_ERASE_SEL, 8'h00, "erase cleared");
    $display("test download done");
    // Second reset in boot mode must load the boot code
    rst <= 1'b1;
    mode_user_boot <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`FDK_OFS_ARRAY_SEL, 8'haa, "boot reset");
    chk("boot reset map", 8'h01, {7'h0, boot_array_sel});
    $display("test boot reset done");
    report_and_stop;
  end
endmodule
bind fdk_top fdk_asserts chk_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .mode_user_prog(mode_user_prog), .exec_from_ram(exec_from_ram), .boot_array_sel(boot_array_sel),
  .prog_erase_enable(prog_erase_enable), .software_protect(software_protect), .dl_busy(dl_busy),
  .dl_done(dl_done), .ram_we(ram_we), .ram_addr(ram_addr));
